/* rtl/arith_move_pkg.sv */
/*
 * Shared constants and types for the signed 16-bit arithmetic and move unit.
 * Assumes a scan engine on the same clock that presents one instruction per request.
 */
package arith_move_pkg;

    localparam int DATA_W = 16;
    localparam int WIDE_W = 32;
    localparam int SIGN_BIT = 15;
    localparam int PROD_SIGN_BIT = 31;
    localparam int DIGIT_BITS = 4;
    localparam int MIN_DIGITS = 1;
    localparam int MAX_DIGITS = 4;
    localparam int SLOT_W = 6;
    localparam int DEFAULT_SLOTS = 64;
    localparam logic [WIDE_W-1:0] LOW_WORD_MASK = 32'h0000ffff;
    localparam logic [WIDE_W-1:0] FULL_MASK = 32'hffffffff;
    localparam logic [WIDE_W-1:0] RESET_DATA = 32'h00000000;

    // Each operation has a plain and a pulse form, chosen by pulse_form.
    typedef enum logic [2:0] {
        multiply_op,
        divide_op,
        add_one_op,
        sub_one_op,
        copy_word_op,
        twos_complement_op
    } op_type;

    typedef struct packed {
        op_type op;
        logic pulse_form;
        logic cond;
        logic [SLOT_W-1:0] slot;
        logic [DATA_W-1:0] src1;
        logic [DATA_W-1:0] src2;
        logic [DATA_W-1:0] dest_now;
        logic dest_is_bits;
        logic [2:0] digits;
        logic dest_illegal;
    } instr_req_type;

    typedef struct packed {
        logic [WIDE_W-1:0] data;
        logic [WIDE_W-1:0] mask;
    } write_type;

endpackage : arith_move_pkg

/* rtl/cond_edge_memory.sv */
/*
 * Remembers the last command condition of every instruction slot.
 * Assumes one sample per slot per scan, on the same clock as the reader.
 */
`timescale 1ns/10ps
`default_nettype none

module cond_edge_memory
    import arith_move_pkg::*;
#(
    parameter int SLOTS = DEFAULT_SLOTS
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic sample,
    input wire logic [SLOT_W-1:0] slot,
    input wire logic cond,
    output logic rise
);

    logic [SLOTS-1:0] last_cond;
    logic [SLOTS-1:0] next_last_cond;

    // Each slot owns one bit, and the memory cannot hold more slots than the slot field can address.
    if (SLOTS < 1 || SLOTS > (1 << SLOT_W)) begin : g_slots_check
        $error("SLOTS out of range");
    end

    always_comb begin
        next_last_cond = last_cond;
        rise = 1'b0;
        if (int'(slot) < SLOTS) begin
            rise = cond & ~last_cond[slot];
            if (sample) begin
                next_last_cond[slot] = cond;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            last_cond <= '0;
        end else begin
            last_cond <= next_last_cond;
        end
    end

endmodule : cond_edge_memory

`default_nettype wire

/* rtl/signed_16bit_arith_move_unit.sv */
/*
 * Signed 16-bit multiply, divide, add one, subtract one, word copy and negate.
 * Each request carries its operation, command condition and instruction slot, both sources,
 * the present destination value and a description of the destination.
 * One cycle after every request the unit answers with done, and if the request runs, with either a write of
 * result data under result mask or an error event that also sets the sticky error flag.
 * Assumes the scan engine on the same clock presents at most one request per cycle with
 * req_valid, supplies the present destination value, and writes result data under result
 * mask when write_en pulses.
 * Assumes the engine lowers the sticky error flag itself by raising error_clear.
 */
// Behaviour
// - Multiply forms the full signed 32-bit product of the two sources.
// - Bit 15 is each source's sign and bit 31 the product's sign.
// - Bit-group destinations fill from bit 0 up, four bits per digit, one to four digits.
// - Divide writes quotient and remainder to a word, only the quotient to a bit group.
// - The quotient sits in the low half and the remainder in the high half of a word.
// - Sources, quotient and remainder of a divide are all signed on bit 15.
// - A zero divisor or an illegal destination raises the error flag.
// - Add one increments the destination value and writes it back.
// - Adding one to 32767 wraps to -32768.
// - Subtract one decrements the destination value and writes it back.
// - Subtracting one from -32768 wraps to 32767.
// - Copy moves the 16-bit source unchanged into the destination.
// - A written destination keeps its value until another write.
// - Negate replaces the destination value with its two's complement.
`timescale 1ns/10ps
`default_nettype none

module signed_16bit_arith_move_unit
    import arith_move_pkg::*;
#(
    parameter int SLOTS = DEFAULT_SLOTS
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire instr_req_type req,
    input wire logic error_clear,
    output write_type result,
    output logic write_en,
    output logic done,
    output logic error_event,
    output logic operation_error_flag
);

    logic rise;
    logic fire;
    logic digits_bad;
    logic bad_dest;
    logic zero_div;
    logic is_multiply;
    logic is_divide;
    logic is_word_op;
    logic signed [WIDE_W-1:0] product;
    logic signed [DATA_W:0] wide_num;
    logic signed [DATA_W:0] wide_den;
    logic signed [DATA_W:0] wide_quot;
    logic signed [DATA_W:0] wide_rem;
    logic [WIDE_W-1:0] quot_rem;
    logic [DATA_W-1:0] word_val;
    logic [5:0] digit_span;
    logic [WIDE_W-1:0] digit_mask;
    logic [WIDE_W-1:0] op_data;
    logic [WIDE_W-1:0] op_mask;
    write_type next_result;
    logic next_write_en;
    logic next_done;
    logic next_error_event;
    logic next_operation_error_flag;

    // The condition memory has one bit per slot, and the slot field cannot address more.
    // A count of zero would leave every slot without an edge detector; one above the range, bits no slot reaches.
    if (SLOTS < 1 || SLOTS > (1 << SLOT_W)) begin : g_slots_check
        $error("SLOTS out of range");
    end

    // One bit per slot remembers the condition seen at the slot's previous evaluation.
    cond_edge_memory #(
        .SLOTS(SLOTS)
    ) edge_mem (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .sample(req_valid),
        .slot(req.slot),
        .cond(req.cond),
        .rise(rise)
    );

    // Operation decode; plain and pulse forms share one code and differ only in pulse_form.
    // Unknown codes match none of these and write zero to the low word when they run.
    always_comb begin
        is_multiply = (req.op == multiply_op);
        is_divide = (req.op == divide_op);
        is_word_op = (req.op == add_one_op) || (req.op == sub_one_op) ||
            (req.op == copy_word_op) || (req.op == twos_complement_op);
    end

    // Whether the request runs, and whether it is refused as an error instead of written.
    always_comb begin
        // Pulse forms look at the slot's previous condition so a held command runs once.
        // A slot beyond SLOTS never shows a rising edge, so only the plain form runs there.
        fire = req_valid & req.cond & (req.pulse_form ? rise : 1'b1);
        // A digit count the group cannot hold is treated like a disallowed destination.
        digits_bad = (int'(req.digits) < MIN_DIGITS) || (int'(req.digits) > MAX_DIGITS);
        bad_dest = req.dest_illegal | (req.dest_is_bits & digits_bad);
        zero_div = is_divide & (req.src2 == 16'h0000);
    end

    // The full signed product of two 16-bit sources always fits in 32 bits.
    // Both sources are widened with their sign before the multiply.
    always_comb begin
        product = WIDE_W'($signed(req.src1)) * WIDE_W'($signed(req.src2));
    end

    // Division runs one bit wider than the operands so that -32768 / -1 cannot trap.
    // The quotient then wraps back to -32768, and the remainder is zero.
    always_comb begin
        wide_num = $signed({req.src1[SIGN_BIT], req.src1});
        // A zero divisor is swapped for one so the divider stays defined; the request errors.
        if (zero_div) begin
            wide_den = 17'sh00001;
        end else begin
            wide_den = $signed({req.src2[SIGN_BIT], req.src2});
        end
        // Both results truncate toward zero; the remainder takes the dividend's sign.
        wide_quot = wide_num / wide_den;
        wide_rem = wide_num % wide_den;
        quot_rem = {wide_rem[DATA_W-1:0], wide_quot[DATA_W-1:0]};
    end

    // Single-word operations; the sums wrap modulo 2^16 and never saturate.
    // Copy needs no arithmetic and is the fall-through value.
    always_comb begin
        word_val = req.src1;
        if (req.op == add_one_op) begin
            word_val = req.dest_now + 16'h0001;
        end else if (req.op == sub_one_op) begin
            word_val = req.dest_now - 16'h0001;
        end else if (req.op == twos_complement_op) begin
            word_val = (~req.dest_now) + 16'h0001;
        end
    end

    // Bit-group destinations keep four bits per digit, filled from bit 0 upward.
    always_comb begin
        // A count of zero gives an empty mask; counts above four are refused anyway.
        digit_span = 6'(int'(req.digits) * DIGIT_BITS);
        digit_mask = FULL_MASK >> (6'(WIDE_W) - digit_span);
    end

    // Data and mask that the engine would commit for this operation.
    always_comb begin
        op_data = RESET_DATA;
        op_mask = LOW_WORD_MASK;
        if (is_multiply) begin
            op_data = product;
            op_mask = FULL_MASK;
        end else if (is_divide) begin
            op_data = quot_rem;
            // A bit group takes the quotient only, so the remainder is masked off.
            op_mask = req.dest_is_bits ? LOW_WORD_MASK : FULL_MASK;
        end else if (is_word_op) begin
            op_data = {16'h0000, word_val};
        end else begin
            // An unknown code writes zero rather than whatever the datapath holds.
            op_data = RESET_DATA;
        end
        if (req.dest_is_bits) begin
            op_mask = op_mask & digit_mask;
        end
    end

    // The data word holds between writes; the engine commits only on write_en.
    always_comb begin
        next_write_en = fire & ~bad_dest & ~zero_div;
        next_result = result;
        if (next_write_en) begin
            // Bits outside the mask are zeroed so a stale high half never shows.
            next_result.data = op_data & op_mask;
            next_result.mask = op_mask;
        end
    end

    // Result and write strobe are registered so the outputs come straight from flip-flops.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            result <= '{data: RESET_DATA, mask: RESET_DATA};
            write_en <= 1'b0;
        end else begin
            result <= next_result;
            write_en <= next_write_en;
        end
    end

    // Done answers every request, whether it ran, was refused or was skipped.
    // The error event is a one-cycle pulse; the flag stands until error_clear.
    always_comb begin
        next_done = req_valid;
        next_error_event = fire & (bad_dest | zero_div);
        // A new error in the clearing cycle is kept, so a clear never hides a fresh error.
        next_operation_error_flag = operation_error_flag & ~error_clear;
        if (next_error_event) begin
            next_operation_error_flag = 1'b1;
        end
    end

    // Status outputs share the request's latency of one cycle.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            done <= 1'b0;
            error_event <= 1'b0;
            operation_error_flag <= 1'b0;
        end else begin
            done <= next_done;
            error_event <= next_error_event;
            operation_error_flag <= next_operation_error_flag;
        end
    end

endmodule : signed_16bit_arith_move_unit

`default_nettype wire

/* verif/arith_move_chk.sv */
/* Port assertions for the arithmetic and move unit.
   Assumes the bind below reaches every unit instance. */
`timescale 1ns/10ps
`default_nettype none
module arith_move_chk
    import arith_move_pkg::*;
#(parameter int SLOTS = DEFAULT_SLOTS) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire instr_req_type req,
    input wire logic error_clear,
    input wire write_type result,
    input wire logic write_en,
    input wire logic done,
    input wire logic error_event,
    input wire logic operation_error_flag
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic run;
    logic word;
    logic [WIDE_W-1:0] prod;
    logic [DATA_W-1:0] lo;
    assign run = req_valid && req.cond && !req.pulse_form;
    assign word = run && !req.dest_is_bits && !req.dest_illegal;
    assign prod = WIDE_W'($signed(req.src1)) * WIDE_W'($signed(req.src2));
    always_comb begin
        case (req.op)
            add_one_op: lo = req.dest_now + 16'h0001;
            sub_one_op: lo = req.dest_now - 16'h0001;
            copy_word_op: lo = req.src1;
            default: lo = 16'h0000 - req.dest_now;
        endcase
    end
    chk_done_latency: assert property (req_valid |=> done) else $error("done missing");
    chk_mul_product: assert property (word && req.op == multiply_op |=> write_en &&
        result.data == $past(prod) && result.mask == FULL_MASK) else $error("bad product");
    chk_word_ops: assert property (word &&
        req.op inside {add_one_op, sub_one_op, copy_word_op, twos_complement_op} |=>
        write_en && result.mask == LOW_WORD_MASK && result.data == {16'h0000, $past(lo)})
        else $error("bad word result");
    chk_div_zero: assert property (run && req.op == divide_op && req.src2 == 16'h0000
        |=> error_event && !write_en && operation_error_flag) else $error("zero divisor");
    chk_bad_dest: assert property (run && req.dest_illegal |=> error_event && !write_en)
        else $error("illegal destination written");
    chk_no_cond: assert property (req_valid && !req.cond |=> !write_en && !error_event)
        else $error("ran without condition");
    chk_result_hold: assert property (!write_en |-> $stable(result))
        else $error("result moved without write");
    chk_flag_sticky: assert property (operation_error_flag && !error_clear
        |=> operation_error_flag) else $error("error flag lost");
    chk_bit_mask: assert property (run && req.dest_is_bits && !req.dest_illegal &&
        req.digits == 3'h1 && req.src2 != 16'h0000 |=> write_en && result.mask == 32'h0000000f)
        else $error("bad one digit mask");
endmodule : arith_move_chk
bind signed_16bit_arith_move_unit arith_move_chk #(.SLOTS(SLOTS)) i_arith_move_chk (.sys_clk,
    .reset_n, .req_valid, .req, .error_clear, .result, .write_en, .done, .error_event,
    .operation_error_flag);
`default_nettype wire

/* verif/tb_signed_16bit_arith_move_unit.sv */
/* Self-checking bench for the arithmetic and move unit.
   Assumes requests spaced two cycles apart, driven on the falling edge. */
`timescale 1ns/10ps
`default_nettype none
module tb_signed_16bit_arith_move_unit
    import arith_move_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    logic error_clear = 1'b0;
    instr_req_type req = '0;
    write_type result;
    logic write_en, done, error_event, operation_error_flag;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    bit prev [64];
    logic [31:0] exp_data = '0;
    logic [31:0] exp_mask = '0;
    logic exp_flag = 1'b0;
    always #5 sys_clk = ~sys_clk;
    signed_16bit_arith_move_unit i_signed_16bit_arith_move_unit (.sys_clk, .reset_n, .req_valid,
        .req, .error_clear, .result, .write_en, .done, .error_event, .operation_error_flag);
    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    task automatic cmp(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp
    function automatic instr_req_type mk(input op_type op, input logic p, input logic c,
        input logic [5:0] sl, input logic [15:0] a, b, dn, input logic bits,
        input logic [2:0] dg, input logic ill);
        return '{op, p, c, sl, a, b, dn, bits, dg, ill};
    endfunction : mk
    task automatic issue(input instr_req_type r, input logic clr);
        int s1, s2, dg, q, rm;
        logic fire, err;
        logic [31:0] d, m;
        s1 = $signed(r.src1);
        s2 = $signed(r.src2);
        dg = r.digits;
        fire = r.cond && !(r.pulse_form && prev[r.slot]);
        prev[r.slot] = r.cond;
        err = fire && (r.dest_illegal || (r.dest_is_bits && (dg < 1 || dg > 4)) ||
            (r.op == divide_op && s2 == 0));
        m = (r.op inside {multiply_op, divide_op}) ? FULL_MASK : LOW_WORD_MASK;
        if (r.dest_is_bits) m = m & ((32'h1 << (4 * dg)) - 1);
        q = (s2 == 0) ? 0 : s1 / s2;
        rm = (s2 == 0) ? 0 : s1 % s2;
        case (r.op)
            multiply_op: d = s1 * s2;
            divide_op: d = {rm[15:0], q[15:0]};
            add_one_op: d = r.dest_now + 16'h0001;
            sub_one_op: d = r.dest_now - 16'h0001;
            copy_word_op: d = r.src1;
            default: d = 32'h0 - r.dest_now;
        endcase
        if (fire && !err) begin
            exp_data = d & m;
            exp_mask = m;
        end
        exp_flag = err || (exp_flag && !clr);
        @(negedge sys_clk);
        req = r;
        req_valid = 1'b1;
        error_clear = clr;
        @(negedge sys_clk);
        req_valid = 1'b0;
        error_clear = 1'b0;
        cmp("done", done, 1);
        cmp("write", write_en, fire && !err);
        cmp("error", error_event, err);
        cmp("flag", operation_error_flag, exp_flag);
        cmp("data", result.data, exp_data);
        cmp("mask", result.mask, exp_mask);
    endtask : issue
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(32'h3d72));
        repeat (16) @(negedge sys_clk);
        reset_n = 1'b1;
        issue(mk(multiply_op, 0, 1, 0, 16'd5678, 16'd1234, 0, 0, 1, 0), 0);
        issue(mk(multiply_op, 0, 1, 1, 16'h8000, 16'h7fff, 0, 0, 1, 0), 0);
        issue(mk(divide_op, 0, 1, 2, 16'hfff9, 16'h0002, 0, 0, 1, 0), 0);
        issue(mk(divide_op, 0, 1, 2, 16'h8000, 16'hffff, 0, 0, 1, 0), 0);
        issue(mk(divide_op, 0, 1, 3, 16'h0064, 16'h0007, 0, 1, 1, 0), 0);
        issue(mk(divide_op, 0, 1, 3, 16'h0001, 16'h0000, 0, 0, 1, 0), 0);
        issue(mk(copy_word_op, 0, 1, 4, 16'h009b, 0, 0, 0, 1, 1), 0);
        issue(mk(copy_word_op, 0, 1, 4, 16'h1234, 0, 0, 1, 5, 0), 0);
        issue(mk(add_one_op, 0, 1, 5, 0, 0, 16'h7fff, 0, 1, 0), 1);
        issue(mk(sub_one_op, 0, 1, 5, 0, 0, 16'h8000, 0, 1, 0), 0);
        issue(mk(twos_complement_op, 0, 1, 5, 0, 0, 16'h8001, 1, 4, 0), 0);
        issue(mk(copy_word_op, 0, 0, 5, 16'hbeef, 0, 0, 0, 1, 0), 0);
        $display("directed cases done");
        for (int i = 0; i < 4; i++) issue(mk(copy_word_op, 1, i != 2, 9, 16'($urandom), 0, 0,
            0, 1, 0), 0);
        $display("pulse form case done");
        repeat (300) issue(mk(op_type'(3'($urandom_range(5))), 1'($urandom), 1'($urandom),
            6'($urandom), 16'($urandom), 16'($urandom), 16'($urandom), 1'($urandom),
            3'($urandom), $urandom_range(15) == 0), $urandom_range(7) == 0);
        $display("random case done");
        complete_run();
    end
endmodule : tb_signed_16bit_arith_move_unit
`default_nettype wire
